// ===== djc_liu.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// (RULE_01) Host: bw high 0, low 1 gives narrow
// (RULE_02) Hardware: straps low=1 high=0 give narrow
// (RULE_03) Host: path bit 1 selects transmit
// (RULE_04) Hardware: path strap 1 selects transmit
// (RULE_05) Recovery-off bit 0 means fast recovery
// (RULE_06) Recovery disable only in host mode
// (RULE_07) Attenuator registers at 0x07, 0x0F, 0x17
// (RULE_08) Hardware: rail strap high gives single rail
// (RULE_09) Tolerate 59 missing clock pulses
// (RULE_10) Mapper should reshape gapped clock and data
// (RULE_11) Minor pattern one: seven pulses, one gap
// (RULE_12) Minor pattern two: five pulses, one gap
// (RULE_13) Each pulse takes one 51.84 MHz slot
// (RULE_14) Major A: 63 of one, 36 of two
// (RULE_15) Edges only for DS3 bits; sample on them
// (RULE_16) Host: channel bit 0 selects single rail
// (RULE_17) Host: rate bits both clear select DS3
// (RULE_18) One bit per pulse, seamless pattern restart
module djc_liu
  import djc_pkg::*;
(
  // System
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Avalon-MM slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Hardware-mode straps
  input  wire logic        host_mode,
  input  wire logic        atten_bw_select_low,
  input  wire logic        atten_bw_select_high,
  input  wire logic        atten_path_select,
  input  wire logic        rail_mode_select,
  // Per-channel effective settings and received link bits
  output logic [DJC_NCH-1:0] narrow_bw,
  output logic [DJC_NCH-1:0] atten_in_tx,
  output logic [DJC_NCH-1:0] fast_recovery,
  output logic [DJC_NCH-1:0] single_rail,
  output logic [DJC_NCH-1:0] ds3_rate,
  output logic [DJC_NCH-1:0] atten_reinit,
  output logic [DJC_NCH-1:0] bit_valid,
  output logic [DJC_NCH-1:0] bit_data,
  // Link
  djc_link_if.liu          link
);
  typedef struct packed {
    logic [DJC_NCH-1:0][7:0] ja;
    logic [DJC_NCH-1:0][7:0] cc;
    logic                    ack;
    logic [31:0]             rd;
    logic [DJC_NCH-1:0]      clk_s1, clk_s2, clk_d;
    logic [DJC_NCH-1:0]      dat_s1, dat_s2;
    logic [DJC_NCH-1:0]      bval, bdat;
    logic [DJC_NCH-1:0][8:0] gap;
    logic [DJC_NCH-1:0]      gap_over;
    logic [DJC_NCH-1:0][4:0] straps_s1, straps_s2;
  } djc_liu_s;
  djc_liu_s st_r, st_nxt;

  function automatic logic [9:0] word_addr(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction

  logic [4:0] straps;
  logic       hw;
  always_comb begin
    straps = {host_mode, rail_mode_select, atten_path_select,
              atten_bw_select_high, atten_bw_select_low};
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    for (int c = 0; c < DJC_NCH; c++) begin
      st_nxt.straps_s1[c] = straps;
      st_nxt.straps_s2[c] = st_r.straps_s1[c];
    end
    // Two-cycle answer keeps the decode registered
    if ((avs_read || avs_write) && !st_r.ack) begin
      st_nxt.ack = 1'b1;
      st_nxt.rd  = 32'h0000_0000;
      for (int c = 0; c < DJC_NCH; c++) begin
        if (avs_address == word_addr(DJC_IDX_JA_CH0 + 8'(8 * c))) begin // RULE_07
          st_nxt.rd = {24'h000000, st_r.ja[c]};
          if (avs_write && avs_byteenable[0])
            st_nxt.ja[c] = avs_writedata[7:0] & DJC_JA_WMASK;
        end
        if (avs_address == word_addr(DJC_IDX_CC_CH0 + 8'(8 * c))) begin
          st_nxt.rd = {24'h000000, st_r.cc[c]};
          if (avs_write && avs_byteenable[0])
            st_nxt.cc[c] = avs_writedata[7:0] & DJC_CC_WMASK;
        end
      end
      if (avs_address == word_addr(DJC_IDX_STATUS))
        st_nxt.rd = {24'h000000, 1'b0, st_r.gap_over, 1'b0, st_r.bval};
    end
    // Link sampling through two flops
    st_nxt.clk_s1 = link.tx_clock_in;
    st_nxt.clk_s2 = st_r.clk_s1;
    st_nxt.dat_s1 = link.tx_positive_data_in;
    st_nxt.dat_s2 = st_r.dat_s1;
    st_nxt.clk_d  = st_r.clk_s2;
    for (int c = 0; c < DJC_NCH; c++) begin
      st_nxt.bval[c] = st_r.clk_s2[c] && !st_r.clk_d[c]; // RULE_15
      if (st_nxt.bval[c]) begin
        st_nxt.bdat[c] = st_r.dat_s2[c];
        st_nxt.gap[c]  = 9'h000;
      end else if (st_r.gap[c] != 9'h1FF) begin
        st_nxt.gap[c] = st_r.gap[c] + 9'h001;
      end
      // Sticky flag only; attenuator keeps running through long gaps
      // Clear only what the read reported, so an event after capture survives
      if (st_r.gap[c] > 9'(DJC_MAX_GAP * DJC_SLOT_DIV)) // RULE_09
        st_nxt.gap_over[c] = 1'b1;
      else if (avs_read && avs_address == word_addr(DJC_IDX_STATUS)
               && st_r.ack && st_r.rd[4 + c])
        st_nxt.gap_over[c] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_r <= '0;
      for (int c = 0; c < DJC_NCH; c++) begin
        st_r.ja[c] <= DJC_JA_RESET;
        st_r.cc[c] <= DJC_CC_RESET;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !st_r.ack;
  assign avs_readdata    = st_r.rd;

  always_comb begin
    hw = !st_r.straps_s2[0][4];
    for (int c = 0; c < DJC_NCH; c++) begin
      if (hw) begin
        narrow_bw[c]   = st_r.straps_s2[c][0] && !st_r.straps_s2[c][1]; // RULE_02
        atten_in_tx[c] = st_r.straps_s2[c][2]; // RULE_04
        fast_recovery[c] = 1'b1; // RULE_06
        single_rail[c] = st_r.straps_s2[c][3]; // RULE_08
        ds3_rate[c]    = 1'b1;
        atten_reinit[c] = 1'b0;
      end else begin
        narrow_bw[c]   = st_r.ja[c][DJC_JA_BWLO_BIT]
                         && !st_r.ja[c][DJC_JA_BWHI_BIT]; // RULE_01
        atten_in_tx[c] = st_r.ja[c][DJC_JA_PATH_BIT]; // RULE_03
        fast_recovery[c] = !st_r.ja[c][DJC_JA_FRO_BIT]; // RULE_05 RULE_06
        single_rail[c] = st_r.cc[c][DJC_CC_RAIL_BIT]; // RULE_16
        ds3_rate[c]    = !st_r.cc[c][DJC_CC_ERATE_BIT]
                         && !st_r.cc[c][DJC_CC_SONET_BIT]; // RULE_17
        atten_reinit[c] = st_r.ja[c][DJC_JA_REINIT_BIT];
      end
    end
  end

  assign bit_valid = st_r.bval;
  assign bit_data  = st_r.bdat;
endmodule
`default_nettype wire

// ===== djc_pkg.sv
package djc_pkg;
  // Register indices; the bus byte address is the index times four
  localparam logic [7:0] DJC_IDX_JA_CH0   = 8'h07;
  localparam logic [7:0] DJC_IDX_JA_CH1   = 8'h0F;
  localparam logic [7:0] DJC_IDX_JA_CH2   = 8'h17;
  localparam logic [7:0] DJC_IDX_CC_CH0   = 8'h06;
  localparam logic [7:0] DJC_IDX_CC_CH1   = 8'h0E;
  localparam logic [7:0] DJC_IDX_CC_CH2   = 8'h16;
  localparam logic [7:0] DJC_IDX_MODE     = 8'h20;
  localparam logic [7:0] DJC_IDX_STATUS   = 8'h21;
  // Attenuator control fields
  localparam int DJC_JA_BWLO_BIT  = 0;
  localparam int DJC_JA_PATH_BIT  = 1;
  localparam int DJC_JA_BWHI_BIT  = 2;
  localparam int DJC_JA_REINIT_BIT = 3;
  localparam int DJC_JA_FRO_BIT   = 4;
  localparam logic [7:0] DJC_JA_WMASK  = 8'h1F;
  localparam logic [7:0] DJC_JA_RESET  = 8'h03;
  // Channel control fields
  localparam int DJC_CC_RAIL_BIT  = 0;
  localparam int DJC_CC_SONET_BIT = 1;
  localparam int DJC_CC_ERATE_BIT = 2;
  localparam logic [7:0] DJC_CC_WMASK  = 8'h3F;
  localparam logic [7:0] DJC_CC_RESET  = 8'h00;
  // Gapped clock pattern
  localparam int DJC_P1_PULSES  = 7;
  localparam int DJC_P2_PULSES  = 5;
  localparam int DJC_P1_REPEATS = 63;
  localparam int DJC_P2_REPEATS = 36;
  localparam int DJC_MAX_GAP    = 59;
  // Slot rate in kHz; the 19.3 ns slot is scaled onto the system clock divider
  localparam int DJC_SLOT_KHZ   = 51840;
  localparam int DJC_CLK_KHZ    = 10000;
  localparam int DJC_SLOT_DIV   = 4;
  localparam int DJC_NCH        = 3;
endpackage

// ===== djc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface djc_link_if;
  import djc_pkg::*;
  logic [DJC_NCH-1:0] tx_clock_in;
  logic [DJC_NCH-1:0] tx_positive_data_in;
  modport mapper (output tx_clock_in, output tx_positive_data_in);
  modport liu    (input tx_clock_in, input tx_positive_data_in);
endinterface
`default_nettype wire

// ===== djc_mapper.sv
`timescale 1ns/1ps
`default_nettype none
module djc_mapper
  import djc_pkg::*;
#(
  parameter int SLOT_DIV = DJC_SLOT_DIV
) (
  // System
  input  wire logic   clk_sys,
  input  wire logic   rstn,
  // User side
  input  wire logic   en,
  input  wire logic [DJC_NCH-1:0] user_bit,
  output logic        user_take,
  output logic [9:0]  pulse_count,
  // Link
  djc_link_if.mapper  link
);
  // Divider counter is eight bits wide and the clock needs a high and a low half
  if (SLOT_DIV < 2 || SLOT_DIV > 256) begin : g_bad_div
    $error("SLOT_DIV must lie between 2 and 256");
  end

  typedef struct packed {
    logic [7:0]         div;
    logic [2:0]         slot;
    logic               p2;
    logic [5:0]         rep;
    logic [DJC_NCH-1:0] clk;
    logic [DJC_NCH-1:0] dat;
    logic [9:0]         cnt;
  } djc_map_s;
  djc_map_s st_r, st_nxt;

  logic tick;
  logic pulse_slot;
  logic [2:0] slot_last;
  always_comb begin
    tick = (st_r.div == 8'(SLOT_DIV - 1));
    slot_last = st_r.p2 ? 3'(DJC_P2_PULSES) : 3'(DJC_P1_PULSES);
    pulse_slot = en && (st_r.slot != slot_last);
    st_nxt = st_r;
    st_nxt.div = tick ? 8'h00 : st_r.div + 8'h01;
    // Clock high in the first half of a slot only when the slot carries a bit
    if (st_r.div == 8'(SLOT_DIV / 2 - 1))
      st_nxt.clk = '0;
    if (tick && en) begin
      st_nxt.clk = {DJC_NCH{pulse_slot}}; // RULE_11 RULE_12 RULE_13 RULE_15
      if (pulse_slot) begin
        st_nxt.dat = user_bit; // RULE_10 RULE_18
        st_nxt.cnt = st_r.cnt + 10'h001;
      end
      if (st_r.slot == slot_last) begin
        st_nxt.slot = 3'h0;
        if (!st_r.p2 && st_r.rep == 6'(DJC_P1_REPEATS - 1)) begin // RULE_14
          st_nxt.p2  = 1'b1;
          st_nxt.rep = 6'h00;
        end else if (st_r.p2 && st_r.rep == 6'(DJC_P2_REPEATS - 1)) begin // RULE_14
          st_nxt.p2  = 1'b0;
          st_nxt.rep = 6'h00;
          st_nxt.cnt = 10'h000; // RULE_18
        end else begin
          st_nxt.rep = st_r.rep + 6'h01;
        end
      end else begin
        st_nxt.slot = st_r.slot + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign user_take = tick && pulse_slot;
  assign pulse_count = st_r.cnt;
  assign link.tx_clock_in = st_r.clk;
  assign link.tx_positive_data_in = st_r.dat;
endmodule
`default_nettype wire

// ===== djc_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module djc_link_properties
  import djc_pkg::*;
(
  // System
  input wire logic               clk_sys,
  input wire logic               rstn,
  // Link
  input wire logic [DJC_NCH-1:0] tx_clock_in,
  input wire logic [DJC_NCH-1:0] tx_positive_data_in
);
  logic       c;
  logic       d;
  logic       rise;
  logic       gap;
  logic [3:0] lo_r;
  logic [3:0] run_r;
  logic [6:0] n7_r;
  logic [6:0] n5_r;
  logic       seen_r;
  // Channel 0 only: all channels share one pattern source
  assign c    = tx_clock_in[0];
  assign d    = tx_positive_data_in[0];
  assign rise = c && (lo_r != 4'h0);
  assign gap  = (lo_r == 4'h6);
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      lo_r   <= 4'h0;
      run_r  <= 4'h0;
      n7_r   <= 7'h00;
      n5_r   <= 7'h00;
      seen_r <= 1'b0;
    end else begin
      lo_r <= c ? 4'h0 : ((lo_r == 4'hF) ? lo_r : lo_r + 4'h1);
      if (rise) begin
        seen_r <= 1'b1;
        run_r  <= (lo_r > 4'h2) ? 4'h1 : run_r + 4'h1;
        if (seen_r && gap && run_r == 4'h7) begin
          n7_r <= n7_r + 7'h01;
          n5_r <= 7'h00;
        end
        if (seen_r && gap && run_r == 4'h5) begin
          n5_r <= n5_r + 7'h01;
          n7_r <= 7'h00;
        end
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_high2; c [*2] ##1 !c; endsequence
  sequence s_gap6; !c [*6] ##1 c; endsequence
  property p_high2; $rose(c) |-> s_high2; endproperty
  property p_gap7; $fell(c) && run_r == 4'h7 |-> s_gap6; endproperty
  property p_lo; rise && seen_r |-> lo_r == 4'h2 || gap; endproperty
  property p_run; run_r <= 4'h7; endproperty
  property p_minor; rise && seen_r && gap |-> run_r == 4'h7 || run_r == 4'h5; endproperty
  property p_maj7;
    rise && seen_r && gap && run_r == 4'h5 && n5_r == 7'h00 |-> n7_r == 7'(DJC_P1_REPEATS);
  endproperty
  property p_maj5;
    rise && seen_r && gap && run_r == 4'h7 && n5_r != 7'h00 |-> n5_r == 7'(DJC_P2_REPEATS);
  endproperty
  property p_data; $rose(c) |=> $stable(d); endproperty
  a_high2: assert property (p_high2) else $error("pulse not two cycles high");
  a_gap7: assert property (p_gap7) else $error("no single gap after seven");
  a_lo: assert property (p_lo) else $error("gap not one slot");
  a_run: assert property (p_run) else $error("pulse run too long");
  a_minor: assert property (p_minor) else $error("minor run length wrong");
  a_maj7: assert property (p_maj7) else $error("first minor count wrong");
  a_maj5: assert property (p_maj5) else $error("second minor count wrong");
  a_data: assert property (p_data) else $error("data moved in pulse");
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import djc_pkg::*;
  logic        clk_sys, rstn, en, user_take, host_mode, avs_read, avs_write, avs_waitrequest;
  logic        atten_bw_select_low, atten_bw_select_high, atten_path_select, rail_mode_select;
  logic [2:0]  user_bit, narrow_bw, atten_in_tx, fast_recovery, single_rail, ds3_rate;
  logic [2:0]  atten_reinit, bit_valid, bit_data;
  logic [9:0]  avs_address, pulse_count;
  logic [31:0] avs_writedata, avs_readdata, rd, v;
  logic [3:0]  avs_byteenable;
  logic [7:0]  jm [3];
  logic [7:0]  cm [3];
  bit          q [3][$];
  int          err_count, total_checks, i, nt, nb;
  localparam int PAT_A_PULSES = DJC_P1_PULSES * DJC_P1_REPEATS + DJC_P2_PULSES * DJC_P2_REPEATS;
  int          seed = 32'h39952431;
  djc_link_if djc_link_if_inst ();
  djc_mapper djc_mapper_inst (.*, .link(djc_link_if_inst));
  djc_liu djc_liu_inst (.*, .link(djc_link_if_inst));
  djc_link_properties djc_link_properties_inst (.clk_sys(clk_sys), .rstn(rstn),
    .tx_clock_in(djc_link_if_inst.tx_clock_in),
    .tx_positive_data_in(djc_link_if_inst.tx_positive_data_in));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic test_done();
    $display("Checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    avs_write     <= w;
    avs_read      <= !w;
    avs_address   <= a;
    avs_writedata <= {24'h0, wd};
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n == 20) begin
      err_count++;
      test_done();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic chk_out();
    logic [17:0] e;
    for (int k = 0; k < 3; k++) begin
      e[15+k] = host_mode ? jm[k][3] : 1'b0;
      e[12+k] = host_mode ? (!jm[k][2] && jm[k][0]) : (atten_bw_select_low && !atten_bw_select_high);
      e[9+k] = host_mode ? jm[k][1] : atten_path_select;
      e[6+k] = host_mode ? !jm[k][4] : 1'b1;
      e[3+k] = host_mode ? cm[k][0] : rail_mode_select;
      e[k] = host_mode ? (!cm[k][1] && !cm[k][2]) : 1'b1;
    end
    chk({14'h0, atten_reinit, narrow_bw, atten_in_tx, fast_recovery, single_rail, ds3_rate},
        {14'h0, e});
  endtask
  // Link model: bits in taken order, one per pulse
  always @(posedge clk_sys) begin
    user_bit <= 3'($random(seed));
    if (user_take === 1'b1) begin
      chk(32'(pulse_count), 32'(nt % PAT_A_PULSES));
      nt++;
    end
    for (int k = 0; k < 3; k++) begin
      if (user_take === 1'b1) q[k].push_back(user_bit[k]);
      if (bit_valid[k] === 1'b1) begin
        chk({31'h0, bit_data[k]}, {31'h0, q[k].pop_front()});
        nb++;
      end
    end
  end
  initial begin
    {rstn, en, avs_read, avs_write, atten_bw_select_low, atten_bw_select_high} = 6'h00;
    {atten_path_select, rail_mode_select, user_bit} = 5'h00;
    {avs_address, avs_writedata, avs_byteenable, host_mode} = {10'h000, 32'h0, 4'hF, 1'b1};
    for (int k = 0; k < 3; k++) {jm[k], cm[k]} = {DJC_JA_RESET, DJC_CC_RESET};
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    // Mapper held idle: the gap counter must cross its limit only after it
    repeat (200) @(posedge clk_sys);
    bus(1'b0, {DJC_IDX_STATUS, 2'b00}, 8'h00);
    chk(rd & 32'h0000_0070, 32'h0000_0000);
    repeat (100) @(posedge clk_sys);
    bus(1'b0, {DJC_IDX_STATUS, 2'b00}, 8'h00);
    chk(rd & 32'h0000_0070, 32'h0000_0070);
    en <= 1'b1;
    repeat (40) @(posedge clk_sys);
    bus(1'b0, {DJC_IDX_STATUS, 2'b00}, 8'h00);
    chk(rd & 32'h0000_0070, 32'h0000_0070);
    bus(1'b0, {DJC_IDX_STATUS, 2'b00}, 8'h00);
    chk(rd & 32'h0000_0070, 32'h0000_0000);
    $display("Test gap done");
    for (int k = 0; k < 3; k++) begin
      bus(1'b0, 10'h01C + 10'(32 * k), 8'h00);
      chk(rd, 32'h03);
      bus(1'b0, 10'h018 + 10'(32 * k), 8'h00);
      chk(rd, 32'h00);
    end
    chk_out();
    $display("Test reset done");
    for (int k = 0; k < 12; k++) begin
      i = k % 3;
      v = $random(seed);
      bus(1'b1, 10'h01C + 10'(32 * i), v[7:0]);
      jm[i] = v[7:0] & DJC_JA_WMASK;
      bus(1'b1, 10'h018 + 10'(32 * i), v[15:8]);
      cm[i] = v[15:8] & DJC_CC_WMASK;
      bus(1'b0, 10'h01C + 10'(32 * i), 8'h00);
      chk(rd, {24'h0, jm[i]});
      chk_out();
    end
    avs_byteenable <= 4'hE;
    bus(1'b1, 10'h01C, 8'hFF);
    avs_byteenable <= 4'hF;
    bus(1'b0, 10'h01C, 8'h00);
    chk(rd, {24'h0, jm[0]});
    bus(1'b1, 10'h3FC, 8'hFF);
    bus(1'b0, 10'h3FC, 8'h00);
    chk(rd, 32'h0);
    $display("Test host done");
    host_mode <= 1'b0;
    for (int k = 0; k < 16; k++) begin
      {atten_bw_select_low, atten_bw_select_high, atten_path_select, rail_mode_select} <= 4'(k);
      repeat (4) @(posedge clk_sys);
      chk_out();
    end
    $display("Test hardware done");
    repeat (7000) @(posedge clk_sys);
    for (int k = 0; k < 3; k++) chk(32'(q[k].size() < 3), 32'h1);
    chk(32'(nb > 3000), 32'h1);
    $display("Test link done");
    test_done();
  end
endmodule
`default_nettype wire
